// ===== design/ict_pkg.sv
// Package for the instruction cycle timing block: operation codes, operand
// kinds and base cycle counts.
// Assumes one core clock; all figures are core clock cycles.
package ict_pkg;

    // Operation selector driven by the decoder
    typedef enum logic [4:0] {
        ICT_OP_PUSH_MEM     = 5'h00,
        ICT_OP_PUSH_REG     = 5'h01,
        ICT_OP_PUSH_SEG     = 5'h02,
        ICT_OP_PUSH_ALL     = 5'h03,
        ICT_OP_PUSH_FLAGS   = 5'h04,
        ICT_OP_RTN_FAR      = 5'h05,
        ICT_OP_RTN_FAR_IMM  = 5'h06,
        ICT_OP_RTN_NEAR     = 5'h07,
        ICT_OP_RTN_NEAR_IMM = 5'h08,
        ICT_OP_ROTATE_LEFT  = 5'h09,
        ICT_OP_ROTATE_RIGHT = 5'h0a,
        ICT_OP_SHIFT_LEFT   = 5'h0b,
        ICT_OP_SHIFT_RIGHT  = 5'h0c,
        ICT_OP_STORE_STRING = 5'h0d,
        ICT_OP_TEST_ACC_IMM = 5'h0e,
        ICT_OP_TEST_RM_IMM  = 5'h0f,
        ICT_OP_TEST_RM_REG  = 5'h10,
        ICT_OP_XOR_ACC_IMM  = 5'h11,
        ICT_OP_XOR_RM_IMM   = 5'h12,
        ICT_OP_XOR_RM_REG   = 5'h13
    } ict_op_t;

    // Shift / rotate count source
    typedef enum logic [1:0] {
        ICT_CNT_ONE    = 2'h0,
        ICT_CNT_REG    = 2'h1,
        ICT_CNT_IMM    = 2'h2
    } ict_cnt_src_t;

    // Decoded instruction handed to the timing block
    typedef struct packed {
        ict_op_t      op;
        logic         mem;       // Operand in memory
        logic         word;      // Word width
        logic         repeated;  // Repeat prefix present
        ict_cnt_src_t cnt_src;
        logic [7:0]   count;     // Shift count or repeat count n
    } ict_instr_t;

    localparam int ICT_CYC_W = 16;

    // Word penalty per memory-using instruction
    localparam logic [ICT_CYC_W-1:0] ICT_WORD_ADD = 16'h0004;

    // Push costs, 16-bit then 8-bit bus
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_MEM16 = 16'h0010;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_MEM8  = 16'h0014;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_REG16 = 16'h000a;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_REG8  = 16'h000e;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_SEG16 = 16'h0009;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSH_SEG8  = 16'h000d;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSHA16    = 16'h0024;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSHA8     = 16'h0044;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSHF16    = 16'h0009;
    localparam logic [ICT_CYC_W-1:0] ICT_PUSHF8     = 16'h000d;

    // Return costs
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_FAR16     = 16'h0016;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_FAR8      = 16'h001e;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_FAR_IMM16 = 16'h0019;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_FAR_IMM8  = 16'h0021;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_NEAR16    = 16'h0010;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_NEAR8     = 16'h0014;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_NIMM16    = 16'h0012;
    localparam logic [ICT_CYC_W-1:0] ICT_RTN_NIMM8     = 16'h0016;

    // Shift and rotate costs
    localparam logic [ICT_CYC_W-1:0] ICT_SH1_REG = 16'h0002;
    localparam logic [ICT_CYC_W-1:0] ICT_SH1_MEM = 16'h000f;
    localparam logic [ICT_CYC_W-1:0] ICT_SHN_REG = 16'h0005;
    localparam logic [ICT_CYC_W-1:0] ICT_SHN_MEM = 16'h0011;

    // Store string costs
    localparam logic [ICT_CYC_W-1:0] ICT_STR_ONE  = 16'h000a;
    localparam logic [ICT_CYC_W-1:0] ICT_STR_BASE = 16'h0006;
    localparam logic [ICT_CYC_W-1:0] ICT_STR_ELEM = 16'h0009;

    // Logic op costs
    localparam logic [ICT_CYC_W-1:0] ICT_ACC_BYTE  = 16'h0003;
    localparam logic [ICT_CYC_W-1:0] ICT_ACC_WORD  = 16'h0004;
    localparam logic [ICT_CYC_W-1:0] ICT_IMM_REG   = 16'h0004;
    localparam logic [ICT_CYC_W-1:0] ICT_TEST_IMEM = 16'h000a;
    localparam logic [ICT_CYC_W-1:0] ICT_XOR_IMEM  = 16'h0010;
    localparam logic [ICT_CYC_W-1:0] ICT_RR_REG    = 16'h0003;
    localparam logic [ICT_CYC_W-1:0] ICT_RR_MEM    = 16'h000a;

    localparam logic [ICT_CYC_W-1:0] ICT_CYC_ONE  = 16'h0001;
    localparam logic [ICT_CYC_W-1:0] ICT_CYC_ZERO = 16'h0000;

endpackage : ict_pkg

// ===== design/ict_cost.sv
// Combinational cost table: decoded instruction to total cycle count.
// Assumes the instruction fields are stable while being read.
`timescale 1ns/1ps
module ict_cost
    import ict_pkg::*;
(
    // Decoded instruction
    input  wire ict_instr_t           i_instr,
    input  wire logic                 i_bus8,
    // Resulting cost
    output logic [ICT_CYC_W-1:0]      o_cycles
);

    logic [ICT_CYC_W-1:0] n_w;
    logic [ICT_CYC_W-1:0] base;
    logic                 mem_xfer;

    // Count widened to the cycle width so sums cannot wrap
    assign n_w = {8'h00, i_instr.count};

    // Base cost per operation, bus width chooses the column for pushes and returns
    always_comb begin
        base     = ICT_CYC_ZERO;
        mem_xfer = 1'b0;
        case (i_instr.op)
            ICT_OP_PUSH_MEM:     base = i_bus8 ? ICT_PUSH_MEM8 : ICT_PUSH_MEM16;
            ICT_OP_PUSH_REG:     base = i_bus8 ? ICT_PUSH_REG8 : ICT_PUSH_REG16;
            ICT_OP_PUSH_SEG:     base = i_bus8 ? ICT_PUSH_SEG8 : ICT_PUSH_SEG16;
            ICT_OP_PUSH_ALL:     base = i_bus8 ? ICT_PUSHA8 : ICT_PUSHA16;
            ICT_OP_PUSH_FLAGS:   base = i_bus8 ? ICT_PUSHF8 : ICT_PUSHF16;
            ICT_OP_RTN_FAR:      base = i_bus8 ? ICT_RTN_FAR8 : ICT_RTN_FAR16;
            ICT_OP_RTN_FAR_IMM:  base = i_bus8 ? ICT_RTN_FAR_IMM8 : ICT_RTN_FAR_IMM16;
            ICT_OP_RTN_NEAR:     base = i_bus8 ? ICT_RTN_NEAR8 : ICT_RTN_NEAR16;
            ICT_OP_RTN_NEAR_IMM: base = i_bus8 ? ICT_RTN_NIMM8 : ICT_RTN_NIMM16;
            ICT_OP_ROTATE_LEFT,
            ICT_OP_ROTATE_RIGHT,
            ICT_OP_SHIFT_LEFT,
            ICT_OP_SHIFT_RIGHT: begin
                mem_xfer = i_instr.mem;
                if (i_instr.cnt_src == ICT_CNT_ONE) begin
                    base = i_instr.mem ? ICT_SH1_MEM : ICT_SH1_REG;
                end else begin
                    base = (i_instr.mem ? ICT_SHN_MEM : ICT_SHN_REG) + n_w;
                end
            end
            ICT_OP_STORE_STRING: begin
                mem_xfer = 1'b1;
                // Product fits: 9 * 255 stays far below 16 bits
                base = i_instr.repeated ?
                       ICT_STR_BASE + ICT_CYC_W'(ICT_STR_ELEM * n_w) :
                       ICT_STR_ONE;
            end
            ICT_OP_TEST_ACC_IMM,
            ICT_OP_XOR_ACC_IMM:
                base = i_instr.word ? ICT_ACC_WORD : ICT_ACC_BYTE;
            ICT_OP_TEST_RM_IMM: begin
                mem_xfer = i_instr.mem;
                base = i_instr.mem ? ICT_TEST_IMEM : ICT_IMM_REG;
            end
            ICT_OP_XOR_RM_IMM: begin
                mem_xfer = i_instr.mem;
                base = i_instr.mem ? ICT_XOR_IMEM : ICT_IMM_REG;
            end
            ICT_OP_TEST_RM_REG,
            ICT_OP_XOR_RM_REG: begin
                mem_xfer = i_instr.mem;
                base = i_instr.mem ? ICT_RR_MEM : ICT_RR_REG;
            end
            default: base = ICT_CYC_ONE;
        endcase
    end

    // One word penalty per memory-using instruction; repeated strings
    // pay it once as well, which keeps the figure simple and bounded
    assign o_cycles = (mem_xfer && i_instr.word) ? base + ICT_WORD_ADD : base;

endmodule : ict_cost

// ===== design/ict_timing.sv
// Instruction cycle timing: holds each accepted instruction for its
// documented number of core clock cycles and then signals completion.
// Assumes the decoder sits on the same clock and holds i_start one cycle.
//
// Notes on behaviour
// - Word memory operations other than push and return add four cycles.
// - Rotate left costs 2/15 or 5+n/17+n.
// - Rotate right costs 2/15 or 5+n/17+n.
// - Shift left costs 2/15 or 5+n/17+n.
// - Shift right costs 2/15 or 5+n/17+n.
// - Returns cost per bus variant and form.
// - Store string: 10, repeated 6+9n.
// - Test costs 3/4, 4/10, 3/10.
// - Exclusive-or costs 3/4, 4/16, 3/10.
`timescale 1ns/1ps
module ict_timing
    import ict_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // Instruction from the decoder
    input  wire logic                 i_start,
    input  wire ict_instr_t           i_instr,
    // Bus variant strap, held static
    input  wire logic                 i_bus8,
    // Status
    output logic                      o_busy,
    output logic                      o_done,
    output logic [ICT_CYC_W-1:0]      o_cycles
);

    typedef enum logic [0:0] {
        ICT_ST_IDLE = 1'b0,
        ICT_ST_RUN  = 1'b1
    } ict_state_t;

    ict_state_t           state_r, state_nxt;
    logic [ICT_CYC_W-1:0] cnt_r, cnt_nxt;
    logic [ICT_CYC_W-1:0] cyc_r, cyc_nxt;
    logic                 done_r, done_nxt;
    logic                 busy_r;
    logic                 bus8_s1_r, bus8_r;
    logic [ICT_CYC_W-1:0] cost;
    wire                  accept;
    wire                  last;

    // Strap is a pin, so it is synchronised before use
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus8_s1_r <= 1'b0;
            bus8_r    <= 1'b0;
        end else begin
            bus8_s1_r <= i_bus8;
            bus8_r    <= bus8_s1_r;
        end
    end

    ict_cost u_cost (
        .i_instr  (i_instr),
        .i_bus8   (bus8_r),
        .o_cycles (cost)
    );

    // Starts while busy are ignored; the decoder must wait for done
    assign accept = i_start && (state_r == ICT_ST_IDLE);
    assign last   = (state_r == ICT_ST_RUN) && (cnt_r == ICT_CYC_ONE);

    // Counter sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        cyc_nxt   = cyc_r;
        done_nxt  = 1'b0;
        case (state_r)
            ICT_ST_IDLE: begin
                if (accept) begin
                    state_nxt = ICT_ST_RUN;
                    cnt_nxt   = cost;
                    cyc_nxt   = cost;
                end
            end
            ICT_ST_RUN: begin
                if (last) begin
                    state_nxt = ICT_ST_IDLE;
                    cnt_nxt   = ICT_CYC_ZERO;
                    done_nxt  = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - ICT_CYC_ONE;
                end
            end
            default: begin
                state_nxt = ICT_ST_IDLE;
                cnt_nxt   = ICT_CYC_ZERO;
            end
        endcase
    end

    // State, counter and status registers; busy is its own flop so the
    // output carries no decode after the state register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ICT_ST_IDLE;
            cnt_r   <= ICT_CYC_ZERO;
            cyc_r   <= ICT_CYC_ZERO;
            done_r  <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cyc_r   <= cyc_nxt;
            done_r  <= done_nxt;
            busy_r  <= (state_nxt == ICT_ST_RUN);
        end
    end

    // Outputs straight from flip-flops
    assign o_busy   = busy_r;
    assign o_done   = done_r;
    assign o_cycles = cyc_r;

endmodule : ict_timing

// ===== dv/ict_timing_properties.sv
// Checker for the cycle timing block: accept, busy span, done pulse, costs.
// Assumes one core clock and the async active-low reset of the top module.
`timescale 1ns/1ps
module ict_timing_chk
    import ict_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_start,
    input  wire ict_instr_t           i_instr,
    input  wire logic                 i_bus8,
    input  wire logic                 o_busy,
    input  wire logic                 o_done,
    input  wire logic [ICT_CYC_W-1:0] o_cycles
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic                 acc;
    logic                 sh;
    logic [ICT_CYC_W-1:0] span_r;
    // Accept and the shift or rotate family each have a decode of their own
    assign acc = i_start && !o_busy;
    assign sh  = i_instr.op inside {ICT_OP_ROTATE_LEFT, ICT_OP_ROTATE_RIGHT,
                                    ICT_OP_SHIFT_LEFT, ICT_OP_SHIFT_RIGHT};
    // Busy cycles since the accept, matched against the cost at done
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) span_r <= '0;
        else if (acc) span_r <= '0;
        else if (o_busy) span_r <= span_r + 16'h0001;
    end
    chk_accept_busy: assert property (acc |=> o_busy) else $error("no busy");
    chk_done_span: assert property (o_done |-> !o_busy && span_r == o_cycles)
        else $error("busy span differs from cost");
    chk_done_single: assert property (o_done |=> !o_done) else $error("long done");
    chk_cycles_hold: assert property (!acc |=> $stable(o_cycles))
        else $error("cost moved without accept");
    chk_shift_one: assert property (acc && sh && i_instr.cnt_src == ICT_CNT_ONE
        && !i_instr.mem |=> o_cycles == 16'h0002) else $error("shift by one cost");
    chk_shift_count: assert property (acc && sh && i_instr.cnt_src != ICT_CNT_ONE
        && i_instr.mem && !i_instr.word |=> o_cycles == 16'h0011 + $past(i_instr.count))
        else $error("shift by count cost");
    chk_word_mem: assert property (acc && i_instr.op == ICT_OP_XOR_RM_IMM
        && i_instr.mem && i_instr.word |=> o_cycles == 16'h0014) else $error("word add");
    chk_test_acc: assert property (acc && i_instr.op == ICT_OP_TEST_ACC_IMM
        |=> o_cycles == ($past(i_instr.word) ? 16'h0004 : 16'h0003)) else $error("test cost");
    chk_store_rep: assert property (acc && i_instr.op == ICT_OP_STORE_STRING
        && i_instr.repeated && !i_instr.word
        |=> o_cycles == 16'h0006 + 16'h0009 * $past(i_instr.count)) else $error("store cost");
    chk_return_near: assert property (acc && i_instr.op == ICT_OP_RTN_NEAR && !i_bus8
        && !$past(i_bus8) && !$past(i_bus8, 2) |=> o_cycles == 16'h0010)
        else $error("near return cost");
    cover property (o_done && i_start);
    cover property (i_start && o_busy);
    cover property (acc ##1 o_busy [*3]);
endmodule : ict_timing_chk

bind ict_timing ict_timing_chk chk_u (.i_clk, .i_reset_n, .i_start, .i_instr, .i_bus8,
                                      .o_busy, .o_done, .o_cycles);

// ===== dv/test_instruction_cycle_timing.sv
// Self-checking bench for the cycle timing block with random instructions.
// Assumes the package costs; expected costs are rebuilt here from the table.
`timescale 1ns/1ps
module test_instruction_cycle_timing;
    import ict_pkg::*;
    logic                 i_clk     = 1'b0;
    logic                 i_reset_n = 1'b0;
    logic                 i_start   = 1'b0;
    ict_instr_t           i_instr   = '0;
    logic                 i_bus8    = 1'b0;
    logic                 o_busy;
    logic                 o_done;
    logic [ICT_CYC_W-1:0] o_cycles;
    logic [31:0]          lfsr      = 32'h00010443;
    logic [ICT_CYC_W-1:0] exp_q[$];
    int                   failures  = 0;
    int                   checked   = 0;
    int                   span      = 0;

    always #10 i_clk = ~i_clk;

    ict_timing dut_u (.i_clk, .i_reset_n, .i_start, .i_instr, .i_bus8,
                      .o_busy, .o_done, .o_cycles);

    function automatic logic [31:0] next_rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h00000000);
        return lfsr;
    endfunction : next_rnd

    // Expected cost; word memory forms add four
    function automatic int cost(ict_instr_t t, logic b8);
        int w;
        int s;
        w = (t.word && t.mem) ? 4 : 0;
        s = (t.cnt_src == ICT_CNT_ONE) ? (t.mem ? 15 : 2) : (t.mem ? 17 : 5) + t.count;
        case (t.op)
            ICT_OP_PUSH_MEM:     return b8 ? 20 : 16;
            ICT_OP_PUSH_REG:     return b8 ? 14 : 10;
            ICT_OP_PUSH_ALL:     return b8 ? 68 : 36;
            ICT_OP_PUSH_SEG, ICT_OP_PUSH_FLAGS: return b8 ? 13 : 9;
            ICT_OP_RTN_FAR:      return b8 ? 30 : 22;
            ICT_OP_RTN_FAR_IMM:  return b8 ? 33 : 25;
            ICT_OP_RTN_NEAR:     return b8 ? 20 : 16;
            ICT_OP_RTN_NEAR_IMM: return b8 ? 22 : 18;
            ICT_OP_STORE_STRING: return (t.repeated ? 6 + 9 * t.count : 10) + (t.word ? 4 : 0);
            ICT_OP_TEST_ACC_IMM, ICT_OP_XOR_ACC_IMM: return t.word ? 4 : 3;
            ICT_OP_TEST_RM_IMM:  return (t.mem ? 10 : 4) + w;
            ICT_OP_XOR_RM_IMM:   return (t.mem ? 16 : 4) + w;
            ICT_OP_TEST_RM_REG, ICT_OP_XOR_RM_REG: return (t.mem ? 10 : 3) + w;
            default:             return s + w;
        endcase
    endfunction : cost

    task automatic check(logic [ICT_CYC_W-1:0] seen, logic [ICT_CYC_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // One accept, then a held start while busy that must be ignored
    task automatic issue();
        logic [31:0] r;
        int          n;
        n = 0;
        while (o_busy !== 1'b0 && n < 400) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        r = next_rnd();
        i_instr = ict_instr_t'(r[17:0]);
        i_instr.op = ict_op_t'(5'(r[31:24] % 20));
        i_instr.cnt_src = ict_cnt_src_t'(2'(r[21:20] % 3));
        i_instr.count = {3'h0, r[26:22]};
        i_start = 1'b1;
        exp_q.push_back(16'(cost(i_instr, i_bus8)));
        @(posedge i_clk);
        #1;
        i_instr = ict_instr_t'(~r[17:0]);
        @(posedge i_clk);
        #1;
        i_start = 1'b0;
    endtask : issue

    // Done pops the oldest note; both the cost and the busy span must match
    always @(negedge i_clk) begin
        if (o_busy === 1'b1) span++;
        if (o_done === 1'b1) begin
            if (exp_q.size() == 0) check(o_cycles, 16'hffff);
            else begin
                check(o_cycles, exp_q[0]);
                check(16'(span), exp_q.pop_front());
            end
            span = 0;
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        check(o_cycles, 16'h0000);
        for (int b = 0; b < 2; b++) begin
            i_bus8 = b[0];
            repeat (3) @(posedge i_clk);
            #1;
            for (int k = 0; k < 150; k++) issue();
        end
        repeat (400) @(posedge i_clk);
        check(16'(exp_q.size()), 16'h0000);
        finish_test();
    end

    // Hang guard, well beyond the longest expected run
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
endmodule : test_instruction_cycle_timing
